// ==== common/spf_cfg.svh ====
// Purpose: Offsets, field positions, reset values and counts of the port
// Assumes: Included by the design file and the bench by bare name
// Notes:   Definitions only
`ifndef SPF_CFG_SVH
`define SPF_CFG_SVH

// ****************************************************************
// Register offsets on the special-function-register bus
// ****************************************************************
`define SPF_ADDR_CTRL 8'hbc
`define SPF_ADDR_STAT 8'hbd
`define SPF_ADDR_DATA 8'hbe

// ****************************************************************
// Control register fields
// ****************************************************************
`define SPF_CTRL_ON 7
`define SPF_CTRL_ROLE 6
`define SPF_CTRL_IDLE 5
`define SPF_CTRL_PHASE 4
`define SPF_CTRL_ORDER 2
`define SPF_CTRL_RATE_HI 1
`define SPF_CTRL_RATE_LO 0
`define SPF_CTRL_MASK 8'hf7
`define SPF_CTRL_RESET 8'h00

// ****************************************************************
// Status register fields
// ****************************************************************
`define SPF_STAT_DONE 7
`define SPF_STAT_WRITE_COLLISION_FLAG 6
`define SPF_STAT_OVF 4
`define SPF_STAT_FULL 3
`define SPF_STAT_BUSY 2
`define SPF_DATA_RESET 8'h00

// ****************************************************************
// Half-period counts of the master clock, in system clocks minus one, and the last edge index of a byte
// ****************************************************************
`define SPF_HALF_DIV2 4'h0
`define SPF_HALF_DIV4 4'h1
`define SPF_HALF_DIV8 4'h3
`define SPF_HALF_DIV16 4'h7
`define SPF_LAST_EDGE 4'hf

`endif

// ==== common/spf_pkg.sv ====
// Purpose: Types shared by the serial flags and data port
// Assumes: Constants come from spf_cfg.svh
// Notes:   Types only
package spf_pkg;
    // Transfer sequencer states
    typedef enum logic [0:0] {
        SPF_IDLE = 1'b0,
        SPF_RUN = 1'b1
    } spf_state_t;
endpackage

// ==== hw/spf_port.sv ====
// Purpose: Control, status flags and data port of a serial peripheral link
// Assumes: Register strobes are one-cycle pulses, pins synchronous to clock
// Notes:   Carries a compact shift engine for both master and slave roles
`timescale 1ns/1ps
`include "spf_cfg.svh"

module spf_port
    import spf_pkg::*;
(
    input wire logic clock_in,          // System clock, 25 MHz
    input wire logic rst_n_in,          // Synchronous reset, active low
    input wire logic [7:0] sfr_addr_in, // Register address
    input wire logic sfr_wr_in,         // Write strobe, one cycle
    input wire logic sfr_rd_in,         // Read strobe, one cycle
    input wire logic [7:0] sfr_wdata_in, // Write data
    output logic [7:0] sfr_rdata_out,   // Read data, one cycle after strobe
    input wire logic irq_ack_in,        // Interrupt vectored, one cycle
    output logic irq_out,               // Transfer-done flag level
    input wire logic sck_in,            // Serial clock pin level
    output logic sck_out,               // Serial clock drive value
    output logic sck_oe_n_out,          // Serial clock enable, low drives
    input wire logic mosi_in,           // Master-out pin level
    output logic mosi_out,              // Master-out drive value
    output logic mosi_oe_n_out,         // Master-out enable, low drives
    input wire logic miso_in,           // Master-in pin level
    output logic miso_out,              // Master-in drive value
    output logic miso_oe_n_out          // Master-in enable, low drives
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Half-period count for the rate field
    function automatic logic [3:0] rate_half(input logic [1:0] rate);
        case (rate)
            2'h0: rate_half = `SPF_HALF_DIV2;
            2'h1: rate_half = `SPF_HALF_DIV4;
            2'h2: rate_half = `SPF_HALF_DIV8;
            default: rate_half = `SPF_HALF_DIV16;
        endcase
    endfunction

    // Shift one bit in at the end away from the outgoing bit
    function automatic logic [7:0] shift_in(input logic [7:0] sh,
                                            input logic b,
                                            input logic bit_order);
        shift_in = bit_order ? {b, sh[7:1]} : {sh[6:0], b};
    endfunction

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [7:0] ctrl_q;       // Control register
    logic [7:0] sh_q;         // Shift register
    logic [7:0] rxbuf_q;      // Receive buffer
    logic [7:0] rdata_q;      // Registered read data
    logic done_flag_q;        // Transfer-done flag
    logic write_collision_flag_q;             // Write-collision flag
    logic ovf_q;              // Receive-overrun flag
    logic full_q;             // Receive-full flag
    logic in_bit_q;           // Bit caught on the sample edge
    logic sck_lvl_q;          // Master clock level
    logic sck_prev_q;         // Last seen slave clock level
    logic [3:0] div_cnt_q;    // Master half-period counter
    logic [3:0] edge_cnt_q;   // Edges seen in this byte
    spf_state_t state_q;      // Sequencer state
    logic on, master, clock_idle_level, clock_phase, bit_order;
    logic busy, wr_ctrl, wr_stat, wr_data, rd_data;
    logic wr_ok, wr_bad, m_tick, s_edge, edge_ev, lead, last, done, din;
    logic [7:0] rx_final;

    assign on = ctrl_q[`SPF_CTRL_ON];
    assign master = ctrl_q[`SPF_CTRL_ROLE];
    assign clock_idle_level = ctrl_q[`SPF_CTRL_IDLE];
    assign clock_phase = ctrl_q[`SPF_CTRL_PHASE];
    assign bit_order = ctrl_q[`SPF_CTRL_ORDER];
    assign busy = (state_q == SPF_RUN);

    // ****************************************************************
    // Register decode
    // ****************************************************************
    assign wr_ctrl = sfr_wr_in && (sfr_addr_in == `SPF_ADDR_CTRL);
    assign wr_stat = sfr_wr_in && (sfr_addr_in == `SPF_ADDR_STAT);
    assign wr_data = sfr_wr_in && (sfr_addr_in == `SPF_ADDR_DATA);
    assign rd_data = sfr_rd_in && (sfr_addr_in == `SPF_ADDR_DATA);
    assign wr_ok = wr_data && !busy;
    assign wr_bad = wr_data && busy;

    // ****************************************************************
    // Edge generation
    // ****************************************************************
    // Master ticks at each half period; the slave watches the pin
    assign m_tick = busy && master && (div_cnt_q == rate_half(ctrl_q[1:0]));
    // An idle slave only starts on an edge leaving the idle level
    assign s_edge = !master && (sck_in != sck_prev_q) &&
                    (busy || (sck_prev_q == clock_idle_level));
    assign edge_ev = on && (master ? m_tick : s_edge);
    assign lead = !edge_cnt_q[0];
    assign last = (edge_cnt_q == `SPF_LAST_EDGE);
    assign done = edge_ev && last;
    assign din = master ? miso_in : mosi_in;
    // Final byte: phase 0 shifts the held bit, phase 1 the live bit
    assign rx_final = shift_in(sh_q, clock_phase ? din : in_bit_q, bit_order);

    // Control register, reserved bit held at zero
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
            ctrl_q <= `SPF_CTRL_RESET;
        else if (wr_ctrl)
            ctrl_q <= sfr_wdata_in & `SPF_CTRL_MASK;
    end

    // Sequencer; leaving enable aborts any byte in flight
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
            state_q <= SPF_IDLE;
        else
        begin
            case (state_q)
                SPF_IDLE:
                    if (on && master && wr_ok)
                        state_q <= SPF_RUN;
                    else if (on && !master && s_edge)
                        state_q <= SPF_RUN;
                SPF_RUN:
                    if (!on || done)
                        state_q <= SPF_IDLE;
                default:
                    state_q <= SPF_IDLE;
            endcase
        end
    end

    // Edge counter; wraps to zero on the sixteenth edge
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in || !on)
            edge_cnt_q <= 4'h0;
        else if (edge_ev)
            edge_cnt_q <= edge_cnt_q + 4'h1;
    end

    // Master divider, halts and clears while idle
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in || !busy || !master)
            div_cnt_q <= 4'h0;
        else if (m_tick)
            div_cnt_q <= 4'h0;
        else
            div_cnt_q <= div_cnt_q + 4'h1;
    end

    // Master clock level toggles per tick, parks at the idle level
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
            sck_lvl_q <= 1'b0;
        else if (!busy)
            sck_lvl_q <= clock_idle_level;
        else if (m_tick)
            sck_lvl_q <= !sck_lvl_q;
    end

    // Slave clock history, read only by the edge detector
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
            sck_prev_q <= 1'b0;
        else
            sck_prev_q <= sck_in;
    end

    // ****************************************************************
    // Shift engine
    // ****************************************************************
    // Sample bit caught on the sample edge of each bit period
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
            in_bit_q <= 1'b0;
        else if (edge_ev && (lead != clock_phase))
            in_bit_q <= din;
    end

    // Shift register: load on an accepted write, shift on shift edges.
    // With phase 1 the first leading edge only exposes the loaded bit.
    // The last phase-1 edge is a sample edge, so the shifter is left
    // alone there: moving the output bit then would break far-side hold.
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
            sh_q <= `SPF_DATA_RESET;
        else if (wr_ok)
            sh_q <= sfr_wdata_in;
        else if (edge_ev)
        begin
            if (clock_phase && lead && (edge_cnt_q != 4'h0))
                sh_q <= shift_in(sh_q, in_bit_q, bit_order);
            else if (!clock_phase && !lead)
                sh_q <= shift_in(sh_q, in_bit_q, bit_order);
        end
    end

    // Receive buffer; a full buffer is kept when acting as slave
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
            rxbuf_q <= `SPF_DATA_RESET;
        else if (done && (master || !full_q))
            rxbuf_q <= rx_final;
    end

    // ****************************************************************
    // Status flags: a hardware set wins over any clear
    // ****************************************************************
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
            done_flag_q <= 1'b0;
        else if (done)
            done_flag_q <= 1'b1;
        else if (irq_ack_in ||
                 (wr_stat && !sfr_wdata_in[`SPF_STAT_DONE]))
            done_flag_q <= 1'b0;
    end

    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
            write_collision_flag_q <= 1'b0;
        else if (wr_bad)
            write_collision_flag_q <= 1'b1;
        else if (wr_ok || (wr_stat && !sfr_wdata_in[`SPF_STAT_WRITE_COLLISION_FLAG]))
            write_collision_flag_q <= 1'b0;
    end

    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
            ovf_q <= 1'b0;
        else if (done && full_q)
            ovf_q <= 1'b1;
        else if (rd_data || (wr_stat && !sfr_wdata_in[`SPF_STAT_OVF]))
            ovf_q <= 1'b0;
    end

    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
            full_q <= 1'b0;
        else if (done)
            full_q <= 1'b1;
        else if (rd_data || (wr_stat && !sfr_wdata_in[`SPF_STAT_FULL]))
            full_q <= 1'b0;
    end

    // Read data, unmapped addresses answer zero
    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
            rdata_q <= 8'h00;
        else if (sfr_rd_in)
        begin
            case (sfr_addr_in)
                `SPF_ADDR_CTRL: rdata_q <= ctrl_q;
                `SPF_ADDR_STAT: rdata_q <= {done_flag_q, write_collision_flag_q, 1'b0,
                                            ovf_q, full_q, busy, 2'b00};
                `SPF_ADDR_DATA: rdata_q <= rxbuf_q;
                default: rdata_q <= 8'h00;
            endcase
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign sfr_rdata_out = rdata_q;
    assign irq_out = done_flag_q;
    assign sck_out = (busy && master) ? sck_lvl_q : clock_idle_level;
    assign mosi_out = bit_order ? sh_q[0] : sh_q[7];
    assign miso_out = bit_order ? sh_q[0] : sh_q[7];
    assign sck_oe_n_out = !(on && master);
    assign mosi_oe_n_out = !(on && master);
    assign miso_oe_n_out = !(on && !master);

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence s_collide;
        wr_data && busy;
    endsequence
    sequence s_master_go;
        wr_data && !busy && on && master;
    endsequence

    a_done_sets: assert property (@(posedge clock_in)
        disable iff (!rst_n_in) done |=> done_flag_q)
        else $error("done flag not set at transfer end");
    a_vector_clears: assert property (@(posedge clock_in)
        disable iff (!rst_n_in) irq_ack_in && !done |=> !done_flag_q)
        else $error("done flag not cleared by vectoring");
    a_collide_drop: assert property (@(posedge clock_in)
        disable iff (!rst_n_in) s_collide and !edge_ev
        |=> write_collision_flag_q && $stable(sh_q))
        else $error("collision write not flagged or not dropped");
    a_write_collision_flag_clear: assert property (@(posedge clock_in)
        disable iff (!rst_n_in) wr_data && !busy |=> !write_collision_flag_q)
        else $error("collision flag kept after idle write");
    a_overrun_set: assert property (@(posedge clock_in)
        disable iff (!rst_n_in) done && full_q |=> ovf_q && full_q)
        else $error("overrun not flagged");
    a_busy_runs: assert property (@(posedge clock_in)
        disable iff (!rst_n_in) s_master_go |=> busy[*2])
        else $error("busy not held after master start");
    a_idle_level: assert property (@(posedge clock_in)
        disable iff (!rst_n_in) (!busy || edge_cnt_q == 4'h0)
        |-> sck_out == clock_idle_level)
        else $error("clock not at idle level");
    a_read_buffer: assert property (@(posedge clock_in)
        disable iff (!rst_n_in) rd_data |=> sfr_rdata_out == $past(rxbuf_q))
        else $error("data read not from receive buffer");
    a_div2_rate: assert property (@(posedge clock_in)
        disable iff (!rst_n_in) s_master_go and (ctrl_q[1:0] == 2'h0)
        |=> ##1 sck_out != clock_idle_level)
        else $error("divide-by-two clock not toggling");
    a_slave_keep: assert property (@(posedge clock_in)
        disable iff (!rst_n_in) done && !master && full_q
        |=> $stable(rxbuf_q))
        else $error("slave overwrote full buffer");
    a_msb_first: assert property (@(posedge clock_in)
        disable iff (!rst_n_in) s_master_go and !bit_order
        |=> mosi_out == $past(sfr_wdata_in[7]))
        else $error("first bit is not the top bit");
endmodule

// ==== verification/spf_peer_model.sv ====
// Purpose: Serial peer that answers the port while it runs as master
// Assumes: Bench arms the peer with a byte before each frame
// Notes:   No select pin, so a frame is the next 16 clock edges after arming
`timescale 1ns/1ps

// ****************************************************************
// Peer slave model
// ****************************************************************
module spf_peer_model (
    input wire logic clock_in,     // System clock
    input wire logic arm_in,       // Load reply byte, start a frame
    input wire logic [7:0] tx_in,  // Reply byte
    input wire logic clock_idle_level_in,      // Idle level of the serial clock
    input wire logic clock_phase_in,      // Phase setting
    input wire logic bit_order_in,      // Bit order, 1 sends LSB first
    input wire logic sck_in,       // Serial clock pin
    input wire logic mosi_in,      // Master-out pin
    output logic miso_out,         // Master-in pin drive
    output logic [7:0] rx_out      // Byte collected from the master
);
    logic [7:0] tx_q = 8'h00;      // Byte being sent
    int bits = 0;                  // Bits already presented
    int edges_seen = 16;           // Edges seen in this frame
    logic lead;                    // Edge leaves the idle level

    // Bit k of the byte in wire order
    function automatic logic pick(input logic [7:0] v, input int k,
                                  input logic l);
        return l ? v[k] : v[7-k];
    endfunction

    initial miso_out = 1'b0;
    initial rx_out = 8'h00;

    // Arming presents bit 0 at once in phase 0, a filler in phase 1
    always @(posedge clock_in)
    begin
        if (arm_in)
        begin
            tx_q = tx_in;
            edges_seen = 0;
            bits = clock_phase_in ? 0 : 1;
            miso_out = clock_phase_in ? ~pick(tx_in, 0, bit_order_in) : pick(tx_in, 0, bit_order_in);
        end
    end

    // Sample on one edge kind, shift on the other; edges off-frame ignored
    always @(sck_in)
    begin
        if (edges_seen < 16 && sck_in !== 1'bx)
        begin
            lead = (sck_in != clock_idle_level_in);
            edges_seen++;
            if (lead ^ clock_phase_in)
                rx_out = bit_order_in ? {mosi_in, rx_out[7:1]} : {rx_out[6:0], mosi_in};
            else if (bits < 8)
            begin
                miso_out = pick(tx_q, bits, bit_order_in);
                bits++;
            end
            // Released line shows the inverse, so stale bits never match
            if (edges_seen == 16)
                miso_out = ~miso_out;
        end
    end
endmodule

// ==== verification/spf_port_tb_top.sv ====
// Purpose: Self-checking bench of the serial flags and data port
// Assumes: Port runs as master against the peer model, then as slave
// Notes:   In the slave role the bench itself clocks the link
`timescale 1ns/1ps
`include "spf_cfg.svh"
module spf_port_tb_top
    import spf_pkg::*;
;
    logic clock_in = 1'b0;        // System clock
    logic rst_n_in = 1'b0;        // Reset, active low
    logic [7:0] addr = 8'h00;     // Register address
    logic [7:0] wdata = 8'h00;    // Write data
    logic wr = 1'b0;              // Write strobe
    logic rd = 1'b0;              // Read strobe
    logic ack = 1'b0;             // Interrupt vectored
    logic arm = 1'b0;             // Peer frame start
    logic [7:0] ptx = 8'h00;      // Peer reply byte
    logic clock_idle_level = 1'b0;            // Settings mirrored to the peer
    logic clock_phase = 1'b0;
    logic bit_order = 1'b0;
    logic ssck = 1'b0;            // Bench serial clock, slave role
    logic smosi = 1'b0;           // Bench master-out bit, slave role
    logic [7:0] srx = 8'h00;      // Bits the port sent as slave
    logic [7:0] rdata, prx;
    logic irq, sck, sck_oe_n, mosi, mosi_oe_n, miso, miso_oe_n, pmiso;
    wire sck_pin = sck_oe_n ? ssck : sck;          // Bench clocks a slave
    wire mosi_pin = mosi_oe_n ? smosi : mosi;      // Bench drives a slave
    wire miso_pin = miso_oe_n ? pmiso : miso;      // Peer drives in master
    int failures = 0;
    int samples_checked = 0;
    int cycles = 0;
    int edges = 0;
    int n;

    always #20 clock_in = ~clock_in;

    spf_port dut (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .sfr_addr_in(addr), .sfr_wr_in(wr), .sfr_rd_in(rd),
        .sfr_wdata_in(wdata), .sfr_rdata_out(rdata), .irq_ack_in(ack),
        .irq_out(irq), .sck_in(sck_pin), .sck_out(sck),
        .sck_oe_n_out(sck_oe_n), .mosi_in(mosi_pin), .mosi_out(mosi),
        .mosi_oe_n_out(mosi_oe_n), .miso_in(miso_pin), .miso_out(miso),
        .miso_oe_n_out(miso_oe_n));

    spf_peer_model peer (.clock_in(clock_in), .arm_in(arm), .tx_in(ptx),
        .clock_idle_level_in(clock_idle_level), .clock_phase_in(clock_phase), .bit_order_in(bit_order), .sck_in(sck_pin),
        .mosi_in(mosi_pin), .miso_out(pmiso), .rx_out(prx));

    // ****************************************************************
    // Watchdog and serial clock edge counter
    // ****************************************************************
    always @(posedge clock_in)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            failures++;
            $display("MISMATCH %0t run hung", $time);
            wrap_up();
        end
    end

    always @(sck) edges++;

    // ****************************************************************
    // Bus tasks, all driven on the falling edge
    // ****************************************************************
    task automatic check(input logic [7:0] got, exp, input string what);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, d);
        @(negedge clock_in);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clock_in);
        wr = 1'b0;
    endtask

    // Read data is registered, so it is looked at one cycle on
    task automatic rd_reg(input logic [7:0] a, exp, input string what);
        @(negedge clock_in);
        addr = a;
        rd = 1'b1;
        @(negedge clock_in);
        rd = 1'b0;
        check(rdata, exp, what);
    endtask

    // Bounded wait for the done flag; n counts system clock cycles since the write
    task automatic wait_done();
        n = 0;
        while (irq !== 1'b1 && n < 400)
        begin
            @(negedge clock_in);
            n++;
        end
        if (n >= 400)
        begin
            failures++;
            $display("MISMATCH %0t transfer never ended", $time);
        end
    endtask

    // Bench acts as link master: clock low 3 cycles, high 2, MSB first
    task automatic slave_byte(input logic [7:0] b);
        for (int k = 7; k >= 0; k--)
        begin
            @(negedge clock_in);
            smosi = b[k];
            repeat (2) @(negedge clock_in);
            srx = {srx[6:0], miso_pin};
            ssck = 1'b1;
            repeat (2) @(negedge clock_in);
            ssck = 1'b0;
        end
    endtask

    task automatic arm_peer(input logic [7:0] p);
        @(negedge clock_in);
        ptx = p;
        arm = 1'b1;
        @(negedge clock_in);
        arm = 1'b0;
        edges = 0;
    endtask

    task automatic wrap_up();
        $display("failures=%0d samples_checked=%0d", failures,
                 samples_checked);
        if (failures == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        repeat (20) @(negedge clock_in);
        rst_n_in = 1'b1;
        rd_reg(`SPF_ADDR_CTRL, 8'h00, "ctrl reset");
        rd_reg(`SPF_ADDR_STAT, 8'h00, "stat reset");
        rd_reg(`SPF_ADDR_DATA, 8'h00, "data reset");
        rd_reg(8'hbf, 8'h00, "unmapped");
        wr_reg(`SPF_ADDR_CTRL, 8'hff);
        rd_reg(`SPF_ADDR_CTRL, 8'hf7, "ctrl bits");
        wr_reg(`SPF_ADDR_CTRL, 8'h00);
        // Disabled port must not start on a data write
        wr_reg(`SPF_ADDR_DATA, 8'h12);
        check({7'h0, sck_oe_n}, 8'h01, "sck driven off");
        rd_reg(`SPF_ADDR_STAT, 8'h00, "no start off");
        // Every rate, both levels, both phases, both orders
        for (int i = 0; i < 4; i++)
        begin
            clock_idle_level = i[0];
            clock_phase = i[1];
            bit_order = i[0] ^ i[1];
            wr_reg(`SPF_ADDR_CTRL, {2'b11, clock_idle_level, clock_phase, 1'b0, bit_order, i[1:0]});
            check({7'h0, sck}, {7'h0, clock_idle_level}, "idle level");
            arm_peer(8'he2 - 8'h31 * i[7:0]);
            wr_reg(`SPF_ADDR_DATA, 8'h1d + 8'h44 * i[7:0]);
            wait_done();
            check(n[7:0], 8'(8 * (2 << i)), "transfer time");
            check(edges[7:0], 8'd16, "edge count");
            check({7'h0, sck}, {7'h0, clock_idle_level}, "idle after");
            check(prx, 8'h1d + 8'h44 * i[7:0], "peer got");
            rd_reg(`SPF_ADDR_STAT, 8'h88, "done full");
            rd_reg(`SPF_ADDR_DATA, ptx, "rx byte");
            wr_reg(`SPF_ADDR_STAT, 8'h7f);
            rd_reg(`SPF_ADDR_STAT, 8'h00, "zero clears");
        end
        // Collisions and overrun, divide by 2, mode 0, MSB first
        clock_idle_level = 1'b0;
        clock_phase = 1'b0;
        bit_order = 1'b0;
        wr_reg(`SPF_ADDR_CTRL, 8'hc0);
        arm_peer(8'h66);
        wr_reg(`SPF_ADDR_DATA, 8'h3c);
        wr_reg(`SPF_ADDR_DATA, 8'hff);
        rd_reg(`SPF_ADDR_STAT, 8'h44, "collide busy");
        wait_done();
        check(prx, 8'h3c, "dropped byte");
        rd_reg(`SPF_ADDR_STAT, 8'hc8, "collide kept");
        wr_reg(`SPF_ADDR_STAT, 8'h7f);
        rd_reg(`SPF_ADDR_STAT, 8'h48, "done only");
        arm_peer(8'h99);
        wr_reg(`SPF_ADDR_DATA, 8'h5a);
        rd_reg(`SPF_ADDR_STAT, 8'h0c, "idle write");
        wr_reg(`SPF_ADDR_DATA, 8'hff);
        wait_done();
        rd_reg(`SPF_ADDR_STAT, 8'hd8, "overrun");
        check(prx, 8'h5a, "second byte");
        wr_reg(`SPF_ADDR_STAT, 8'hbf);
        rd_reg(`SPF_ADDR_STAT, 8'h98, "zero write_collision_flag");
        rd_reg(`SPF_ADDR_DATA, 8'h99, "newest byte");
        rd_reg(`SPF_ADDR_STAT, 8'h80, "read clears");
        @(negedge clock_in);
        ack = 1'b1;
        @(negedge clock_in);
        ack = 1'b0;
        rd_reg(`SPF_ADDR_STAT, 8'h00, "vectored");
        check({7'h0, irq}, 8'h00, "irq low");
        // Slave role, mode 0: preloaded byte goes out, full buffer is kept
        wr_reg(`SPF_ADDR_CTRL, 8'h80);
        wr_reg(`SPF_ADDR_DATA, 8'ha5);
        slave_byte(8'h3c);
        check(srx, 8'ha5, "slave sent");
        rd_reg(`SPF_ADDR_STAT, 8'h88, "slave done");
        slave_byte(8'hc3);
        check(srx, 8'h3c, "slave echo");
        rd_reg(`SPF_ADDR_STAT, 8'h98, "slave overrun");
        rd_reg(`SPF_ADDR_DATA, 8'h3c, "slave kept");
        wrap_up();
    end
endmodule
